//--- uta_pkg.sv
// Package for the serial transceiver auxiliary timing register block.
// Assumes a plain strobe-based register port with word-sized offsets.
package uta_pkg;
	// ==========================================================
	// Register offsets
	localparam logic [7:0] OFF_IDLE    = 8'h00;
	localparam logic [7:0] OFF_GUARD   = 8'h04;
	localparam logic [7:0] OFF_RATIO   = 8'h08;
	localparam logic [7:0] OFF_ERRS    = 8'h0C;
	localparam logic [7:0] OFF_IRFILT  = 8'h10;
	localparam logic [7:0] OFF_CTRL    = 8'h14;
	localparam logic [7:0] OFF_STATUS  = 8'h18;
	localparam logic [7:0] OFF_MASK    = 8'h1C;
	// ==========================================================
	// Field widths and reset values
	localparam int IDLE_W  = 16;
	localparam int GUARD_W = 8;
	localparam int RATIO_W = 11;
	localparam int ERRS_W  = 8;
	localparam int IRF_W   = 8;
	localparam logic [10:0] RATIO_RST = 11'h174;
	// Control register bits
	localparam int CTRL_RESTART = 0;
	localparam int CTRL_CARD    = 1;
	// Status bits
	localparam int ST_TIMEOUT = 0;
	localparam int ST_ERRSAT  = 1;
	localparam int ST_W       = 2;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [31:0] wdata;
	} uta_bus_t;
endpackage : uta_pkg

//--- uta_regs.sv
// Auxiliary timing registers: idle time-out, guard time, card clock
// divider, card error tally and infrared filter setting.
// Assumes a bit-period tick from the baud generator and synchronous pins.
//
// Summary of operation
// - Idle limit zero disables the receive time-out entirely.
// - Idle limit N gives a time-out after N bit periods.
// - Guard value zero inserts no gap between characters.
// - Guard value N inserts N bit periods between characters.
// - In card mode a zero ratio stops the baud output.
// - In card mode baud is card clock divided by ratio.
// - Card transfer errors are counted into the error field.
// - Reading the error register returns the count and clears it.
// - The infrared filter setting drives the demodulator filter.
// - Time-out flag sets after idle delay from restart, held until restart or a zero idle limit.
//
// The address map and strobed register access were left to the implementer.
`timescale 1ns/10ps
module uta_regs
	import uta_pkg::*;
#(
	parameter int IDLE_BITS = IDLE_W
) (
	// Clock, reset, enable
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        clkEn,
	// Register port
	input  wire logic [7:0]  addr,
	input  wire logic [31:0] wdata,
	input  wire logic        wrStb,
	input  wire logic        rdStb,
	output logic      [31:0] rdata,
	// Transceiver side
	input  wire logic        bitTick,
	input  wire logic        rxActive,
	input  wire logic        stopBitDone,
	input  wire logic        cardClkEdge,
	input  wire logic        cardError,
	output logic             guardHold,
	output logic             cardBaudTick,
	output logic [7:0]       irFilter,
	output logic             irq
);
	// ==========================================================
	// Reset synchroniser
	logic rstMeta_q;
	logic rstSync_q;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rstMeta_q <= 1'b0;
			rstSync_q <= 1'b0;
		end else begin
			rstMeta_q <= 1'b1;
			rstSync_q <= rstMeta_q;
		end
	end
	wire logic rs = rstSync_q;

	uta_bus_t bus;
	assign bus = '{wr: wrStb, rd: rdStb, addr: addr, wdata: wdata};

	// ==========================================================
	// Register file
	logic [IDLE_BITS-1:0] idleDelayValue_q, idleDelayValue_d;
	logic [GUARD_W-1:0]   guardDelayValue_q, guardDelayValue_d;
	logic [RATIO_W-1:0]   cardClockDivisor_q, cardClockDivisor_d;
	logic [IRF_W-1:0]     irFilter_q, irFilter_d;
	logic                 cardMode_q, cardMode_d;
	logic [ST_W-1:0]      mask_q, mask_d;
	logic                 restartCmd;
	always_comb begin
		idleDelayValue_d   = idleDelayValue_q;
		guardDelayValue_d  = guardDelayValue_q;
		cardClockDivisor_d = cardClockDivisor_q;
		irFilter_d         = irFilter_q;
		cardMode_d         = cardMode_q;
		mask_d             = mask_q;
		restartCmd         = 1'b0;
		if (bus.wr) begin
			case (bus.addr)
				OFF_IDLE:   idleDelayValue_d = bus.wdata[IDLE_BITS-1:0];
				OFF_GUARD:  guardDelayValue_d = bus.wdata[GUARD_W-1:0];
				OFF_RATIO:  cardClockDivisor_d = bus.wdata[RATIO_W-1:0];
				OFF_IRFILT: irFilter_d = bus.wdata[IRF_W-1:0];
				OFF_CTRL: begin
					cardMode_d = bus.wdata[CTRL_CARD];
					restartCmd = bus.wdata[CTRL_RESTART];
				end
				OFF_MASK:   mask_d = bus.wdata[ST_W-1:0];
				default:    ;
			endcase
		end
	end
	always_ff @(posedge clk or negedge rs) begin
		if (!rs) begin
			idleDelayValue_q   <= '0;
			guardDelayValue_q  <= '0;
			cardClockDivisor_q <= RATIO_RST;
			irFilter_q         <= '0;
			cardMode_q         <= 1'b0;
			mask_q             <= '0;
		end else if (clkEn) begin
			idleDelayValue_q   <= idleDelayValue_d;
			guardDelayValue_q  <= guardDelayValue_d;
			cardClockDivisor_q <= cardClockDivisor_d;
			irFilter_q         <= irFilter_d;
			cardMode_q         <= cardMode_d;
			mask_q             <= mask_d;
		end
	end

	// ==========================================================
	// Receive idle time-out
	logic [IDLE_BITS-1:0] idleCnt_q, idleCnt_d;
	logic                 idleRun_q, idleRun_d;
	logic                 timeoutEv;
	always_comb begin
		idleCnt_d = idleCnt_q;
		idleRun_d = idleRun_q;
		timeoutEv = 1'b0;
		if (idleDelayValue_q == '0) begin
			idleRun_d = 1'b0;
			idleCnt_d = '0;
		end else if (restartCmd) begin
			idleRun_d = 1'b1;
			idleCnt_d = '0;
		end else if (idleRun_q && rxActive) begin
			idleCnt_d = '0;
		end else if (idleRun_q && bitTick) begin
			if (idleCnt_q + 1'b1 == idleDelayValue_q) begin
				timeoutEv = 1'b1;
				idleRun_d = 1'b0;
			end
			idleCnt_d = idleCnt_q + 1'b1;
		end
	end
	always_ff @(posedge clk or negedge rs) begin
		if (!rs) begin
			idleCnt_q <= '0;
			idleRun_q <= 1'b0;
		end else if (clkEn) begin
			idleCnt_q <= idleCnt_d;
			idleRun_q <= idleRun_d;
		end
	end

	// ==========================================================
	// Transmit guard time
	logic [GUARD_W-1:0] guardCnt_q, guardCnt_d;
	logic               guardHold_q, guardHold_d;
	always_comb begin
		guardCnt_d  = guardCnt_q;
		guardHold_d = guardHold_q;
		if (stopBitDone && guardDelayValue_q != '0) begin
			guardHold_d = 1'b1;
			guardCnt_d  = '0;
		end else if (guardHold_q && bitTick) begin
			if (guardCnt_q + 1'b1 >= guardDelayValue_q)
				guardHold_d = 1'b0;
			guardCnt_d = guardCnt_q + 1'b1;
		end
		if (guardDelayValue_q == '0)
			guardHold_d = 1'b0;
	end
	always_ff @(posedge clk or negedge rs) begin
		if (!rs) begin
			guardCnt_q  <= '0;
			guardHold_q <= 1'b0;
		end else if (clkEn) begin
			guardCnt_q  <= guardCnt_d;
			guardHold_q <= guardHold_d;
		end
	end

	// ==========================================================
	// Card clock divider, counts card clock edges
	logic [RATIO_W-1:0] divCnt_q, divCnt_d;
	logic               baud_q, baud_d;
	always_comb begin
		divCnt_d = divCnt_q;
		baud_d   = 1'b0;
		if (!cardMode_q || cardClockDivisor_q == '0) begin
			divCnt_d = '0;
		end else if (cardClkEdge) begin
			if (divCnt_q + 1'b1 >= cardClockDivisor_q) begin
				divCnt_d = '0;
				baud_d   = 1'b1;
			end else begin
				divCnt_d = divCnt_q + 1'b1;
			end
		end
	end
	always_ff @(posedge clk or negedge rs) begin
		if (!rs) begin
			divCnt_q <= '0;
			baud_q   <= 1'b0;
		end else if (clkEn) begin
			divCnt_q <= divCnt_d;
			baud_q   <= baud_d;
		end
	end

	// ==========================================================
	// Error tally, status, read port
	logic [ERRS_W-1:0] errCnt_q, errCnt_d;
	logic [ST_W-1:0]   status_q, status_d;
	logic [31:0]       rdata_q, rdata_d;
	logic              irq_q, irq_d;
	logic              errSatEv;
	always_comb begin
		errCnt_d = errCnt_q;
		errSatEv = 1'b0;
		rdata_d  = '0;
		status_d = status_q;
		if (bus.rd) begin
			case (bus.addr)
				OFF_IDLE:   rdata_d[IDLE_BITS-1:0] = idleDelayValue_q;
				OFF_GUARD:  rdata_d[GUARD_W-1:0] = guardDelayValue_q;
				OFF_RATIO:  rdata_d[RATIO_W-1:0] = cardClockDivisor_q;
				OFF_ERRS:   rdata_d[ERRS_W-1:0] = errCnt_q;
				OFF_IRFILT: rdata_d[IRF_W-1:0] = irFilter_q;
				OFF_CTRL:   rdata_d[CTRL_CARD] = cardMode_q;
				OFF_STATUS: rdata_d[ST_W-1:0] = status_q;
				OFF_MASK:   rdata_d[ST_W-1:0] = mask_q;
				default:    rdata_d = '0;
			endcase
		end
		if (bus.rd && bus.addr == OFF_ERRS)
			errCnt_d = '0;
		if (bus.rd && bus.addr == OFF_STATUS)
			status_d[ST_ERRSAT] = 1'b0;
		if (restartCmd || idleDelayValue_q == '0)
			status_d[ST_TIMEOUT] = 1'b0;
		// count card errors; error after read-clear counts as one
		if (cardError && cardMode_q) begin
			if (errCnt_d != '1)
				errCnt_d = errCnt_d + 1'b1;
			else
				errSatEv = 1'b1;
		end
		// Sets win over clears
		if (timeoutEv)
			status_d[ST_TIMEOUT] = 1'b1;
		if (errSatEv)
			status_d[ST_ERRSAT] = 1'b1;
		irq_d = |(status_d & mask_d);
	end
	always_ff @(posedge clk or negedge rs) begin
		if (!rs) begin
			errCnt_q <= '0;
			status_q <= '0;
			rdata_q  <= '0;
			irq_q    <= 1'b0;
		end else if (clkEn) begin
			errCnt_q <= errCnt_d;
			status_q <= status_d;
			rdata_q  <= rdata_d;
			irq_q    <= irq_d;
		end
	end

	assign rdata        = rdata_q;
	assign guardHold    = guardHold_q;
	assign cardBaudTick = baud_q;
	assign irFilter     = irFilter_q;
	assign irq          = irq_q;

	// ==========================================================
	// Checks
	sequence restartSeq;
		clkEn && restartCmd;
	endsequence
	// A zero limit may be written while the counter runs: stop next cycle
	idle_zero_a: assert property (@(posedge clk) disable iff (!rs)
		clkEn && idleDelayValue_q == '0
		|=> !idleRun_q && !status_q[ST_TIMEOUT])
		else $error("time-out active while disabled");
	idle_count_a: assert property (@(posedge clk) disable iff (!rs)
		clkEn && timeoutEv |-> idleCnt_q + 1'b1 == idleDelayValue_q
		##1 status_q[ST_TIMEOUT] && !idleRun_q)
		else $error("time-out at wrong count");
	guard_zero_a: assert property (@(posedge clk) disable iff (!rs)
		guardDelayValue_q == '0 |=> !guardHold_q || $changed(guardDelayValue_q))
		else $error("guard held with zero value");
	guard_start_a: assert property (@(posedge clk) disable iff (!rs)
		clkEn && stopBitDone && guardDelayValue_q != '0 |=> guardHold)
		else $error("guard not started after stop bit");
	guard_len_a: assert property (@(posedge clk) disable iff (!rs)
		guardHold_q && !$past(guardHold_q) |-> guardCnt_q == '0)
		else $error("guard count not restarted");
	baud_zero_a: assert property (@(posedge clk) disable iff (!rs)
		$past(cardClockDivisor_q) == '0 |-> !cardBaudTick)
		else $error("baud tick with zero ratio");
	baud_div_a: assert property (@(posedge clk) disable iff (!rs)
		cardBaudTick |-> $past(divCnt_q) + 1'b1 >= $past(cardClockDivisor_q))
		else $error("baud tick too early");
	err_read_a: assert property (@(posedge clk) disable iff (!rs)
		clkEn && bus.rd && bus.addr == OFF_ERRS && !cardError
		|=> errCnt_q == '0 && rdata[ERRS_W-1:0] == $past(errCnt_q))
		else $error("error tally not cleared on read");
	err_sat_a: assert property (@(posedge clk) disable iff (!rs)
		errCnt_q == '1 && !(bus.rd && bus.addr == OFF_ERRS) && clkEn
		|=> errCnt_q == '1)
		else $error("error tally wrapped");
	err_count_a: assert property (@(posedge clk) disable iff (!rs)
		clkEn && cardError && cardMode_q && errCnt_q == 8'h00
		|=> errCnt_q == 8'h01)
		else $error("error not counted");
	restart_clr_a: assert property (@(posedge clk) disable iff (!rs)
		restartSeq |=> !status_q[ST_TIMEOUT])
		else $error("time-out flag survived restart");
	ir_filt_a: assert property (@(posedge clk) disable iff (!rs)
		clkEn && bus.wr && bus.addr == OFF_IRFILT
		|=> irFilter == $past(bus.wdata[IRF_W-1:0]))
		else $error("filter setting not applied");
endmodule : uta_regs

//--- uta_peer.sv
// Serial line peer: bit clock, card clock edges, card errors, stop bits.
// Assumes requests from the bench arrive synchronous to clk.
`timescale 1ns/10ps
module uta_peer #(
	parameter int TICK_P = 8
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rstn,
	// Requests from the bench
	input  wire logic        errReq,
	input  wire logic        stopReq,
	input  wire logic        cardOn,
	input  wire logic        rxReq,
	// Device side
	input  wire logic        guardHold,
	input  wire logic        cardBaudTick,
	output logic             bitTick,
	output logic             rxActive,
	output logic             stopBitDone,
	output logic             cardClkEdge,
	output logic             cardError,
	// Observed totals
	output logic      [15:0] baudCnt,
	output logic      [15:0] holdCnt
);
	int div;
	// ==========================================================
	// Line activity
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			div <= 0;
			bitTick <= 1'b0;
			{rxActive, stopBitDone, cardClkEdge, cardError} <= 4'h0;
			baudCnt <= 16'h0;
			holdCnt <= 16'h0;
		end else begin
			div <= (div == TICK_P - 1) ? 0 : div + 1;
			bitTick <= (div == 0);
			{rxActive, stopBitDone, cardClkEdge, cardError} <=
				{rxReq, stopReq, cardOn, errReq};
			baudCnt <= baudCnt + {15'h0, cardBaudTick};
			holdCnt <= holdCnt + {15'h0, guardHold};
		end
	end
endmodule : uta_peer

//--- tb_usart_timing_iso_aux_regs.sv
// Self-checking bench for the auxiliary timing register block.
// Assumes the peer model supplies all line-side pulses.
`timescale 1ns/10ps
module tb_usart_timing_iso_aux_regs;
	import uta_pkg::*;
	localparam int P = 8;
	logic clk, rstn, clkEn, wrStb, rdStb, guardHold, cardBaudTick, irq;
	logic errReq, stopReq, cardOn, rxReq;
	logic bitTick, rxActive, stopBitDone, cardClkEdge, cardError;
	logic [7:0]  addr, irFilter;
	logic [31:0] wdata, rdata, d;
	logic [15:0] baudCnt, holdCnt, h0;
	int n_errors, n_checks, cyc, n, lo, hi;
	logic [7:0] offs [8] = '{OFF_IDLE, OFF_GUARD, OFF_RATIO, OFF_ERRS,
		OFF_IRFILT, OFF_STATUS, OFF_MASK, 8'h20};
	int wid [5] = '{IDLE_W, GUARD_W, RATIO_W, ERRS_W, IRF_W};

	uta_regs dut (.clk(clk), .rstn(rstn), .clkEn(clkEn), .addr(addr),
		.wdata(wdata), .wrStb(wrStb), .rdStb(rdStb), .rdata(rdata),
		.bitTick(bitTick), .rxActive(rxActive), .stopBitDone(stopBitDone),
		.cardClkEdge(cardClkEdge), .cardError(cardError),
		.guardHold(guardHold), .cardBaudTick(cardBaudTick),
		.irFilter(irFilter), .irq(irq));
	uta_peer #(.TICK_P(P)) peer (.clk(clk), .rstn(rstn), .errReq(errReq),
		.stopReq(stopReq), .cardOn(cardOn), .rxReq(rxReq),
		.guardHold(guardHold), .cardBaudTick(cardBaudTick),
		.bitTick(bitTick), .rxActive(rxActive), .stopBitDone(stopBitDone),
		.cardClkEdge(cardClkEdge), .cardError(cardError),
		.baudCnt(baudCnt), .holdCnt(holdCnt));

	// ==========================================================
	// Helpers
	function automatic logic [31:0] fmask(int w);
		return (32'h1 << w) - 32'h1;
	endfunction : fmask
	task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value %s exp %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic wr(logic [7:0] a, logic [31:0] v);
		@(posedge clk);
		{wrStb, addr, wdata} <= {1'b1, a, v};
		@(posedge clk);
		wrStb <= 1'b0;
	endtask : wr
	task automatic rd(logic [7:0] a, output logic [31:0] v);
		@(posedge clk);
		{rdStb, addr} <= {1'b1, a};
		@(posedge clk);
		rdStb <= 1'b0;
		#1 v = rdata;
	endtask : rd
	task automatic pulse_err(int k);
		repeat (k) begin
			@(posedge clk) errReq <= 1'b1;
			@(posedge clk) errReq <= 1'b0;
		end
	endtask : pulse_err
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : tally_and_finish

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			n_errors++;
			tally_and_finish;
		end
	end

	// ==========================================================
	// Main sequence
	initial begin
		{rstn, wrStb, rdStb, errReq, stopReq, cardOn, rxReq} = 7'h0;
		{addr, wdata} = 40'h0;
		clkEn = 1'b1;
		{n_errors, n_checks, cyc} = 0;
		void'($urandom(12));
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		repeat (4) @(posedge clk);
		for (int i = 0; i < 8; i++) begin
			rd(offs[i], d);
			check("reset", d, (i == 2) ? {21'h0, RATIO_RST} : 32'h0);
		end
		for (int i = 0; i < 5; i++) begin
			if (i == 3) continue;
			n = $urandom;
			wr(offs[i], n);
			rd(offs[i], d);
			check("field", d, n & fmask(wid[i]));
		end
		wr(8'h20, 32'hFFFF_FFFF);
		rd(8'h20, d);
		check("unmapped", d, 32'h0);
		check("irfilter", {24'h0, irFilter}, n & 32'hFF);
		// errors only count in card mode
		wr(OFF_CTRL, 32'h2);
		n = 1 + $urandom % 20;
		pulse_err(n);
		rd(OFF_ERRS, d);
		check("errs", d, n);
		rd(OFF_ERRS, d);
		check("errs clr", d, 32'h0);
		wr(OFF_MASK, 32'h3);
		pulse_err(300);
		rd(OFF_ERRS, d);
		check("errs sat", d, 32'hFF);
		check("irq set", {31'h0, irq}, 32'h1);
		rd(OFF_STATUS, d);
		check("sat flag", {31'h0, d[ST_ERRSAT]}, 32'h1);
		repeat (2) @(posedge clk);
		check("irq clr", {31'h0, irq}, 32'h0);
		wr(OFF_IDLE, 32'h0);
		wr(OFF_CTRL, 32'h1);
		repeat (40 * P) @(posedge clk);
		rd(OFF_STATUS, d);
		check("no tmo", {31'h0, d[ST_TIMEOUT]}, 32'h0);
		n = 2 + $urandom % 4;
		wr(OFF_IDLE, n);
		wr(OFF_CTRL, 32'h1);
		// Margin keeps the early look clear of the bit-tick phase
		repeat ((n - 1) * P - 2) @(posedge clk);
		rd(OFF_STATUS, d);
		check("tmo early", {31'h0, d[ST_TIMEOUT]}, 32'h0);
		repeat (2 * P) @(posedge clk);
		rd(OFF_STATUS, d);
		check("tmo set", {31'h0, d[ST_TIMEOUT]}, 32'h1);
		check("tmo irq", {31'h0, irq}, 32'h1);
		rd(OFF_STATUS, d);
		check("tmo held", {31'h0, d[ST_TIMEOUT]}, 32'h1);
		wr(OFF_CTRL, 32'h1);
		rd(OFF_STATUS, d);
		check("tmo restart", {31'h0, d[ST_TIMEOUT]}, 32'h0);
		// Receive activity keeps restarting the idle count
		@(posedge clk) rxReq <= 1'b1;
		repeat ((n + 2) * P) @(posedge clk);
		rd(OFF_STATUS, d);
		check("tmo rx busy", {31'h0, d[ST_TIMEOUT]}, 32'h0);
		@(posedge clk) rxReq <= 1'b0;
		repeat ((n + 1) * P) @(posedge clk);
		rd(OFF_STATUS, d);
		check("tmo rx idle", {31'h0, d[ST_TIMEOUT]}, 32'h1);
		// Guard of zero, then a random non-zero guard
		for (int g = 0; g < 2; g++) begin
			n = g * (1 + $urandom % 6);
			wr(OFF_GUARD, n);
			h0 = holdCnt;
			@(posedge clk) stopReq <= 1'b1;
			@(posedge clk) stopReq <= 1'b0;
			repeat ((n + 3) * P) @(posedge clk);
			lo = (n == 0) ? 0 : (n - 1) * P;
			hi = (n == 0) ? 0 : (n + 1) * P;
			check("guard", ((holdCnt - h0) >= lo) && ((holdCnt - h0) <= hi),
				32'h1);
		end
		// Card baud: random ratio, then zero ratio
		for (int r = 0; r < 2; r++) begin
			n = (r == 0) ? 1 + $urandom % 7 : 0;
			wr(OFF_RATIO, n);
			wr(OFF_CTRL, 32'h2);
			h0 = baudCnt;
			@(posedge clk) cardOn <= 1'b1;
			repeat (70) @(posedge clk);
			cardOn <= 1'b0;
			repeat (4) @(posedge clk);
			check("baud", baudCnt - h0, (n == 0) ? 0 : 70 / n);
		end
		// Clock enable low freezes the register file
		d = {24'h0, irFilter};
		@(posedge clk) clkEn <= 1'b0;
		wr(OFF_IRFILT, ~d);
		@(posedge clk) clkEn <= 1'b1;
		repeat (2) @(posedge clk);
		check("frozen", {24'h0, irFilter}, d);
		tally_and_finish;
	end
endmodule : tb_usart_timing_iso_aux_regs
